// ### hw/clksm_top.sv
// Clock select and monitor: glitch-free source switch, divide by two,
// activity detectors, external stabilisation and gated control bits.
// Assumes all clock pins are sampled by i_clk at 40 MHz, so each
// source must stay well below a quarter of that rate to be seen.
`timescale 1ns/1ps
`default_nettype none

module clksm_top
  import clksm_pkg::*;
#(
  parameter int STAB_COUNT = CLKSM_STAB_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Clock sources, references and frequency status, all asynchronous pins
  input wire logic i_external_clock,
  input wire logic i_internal_clock,
  input wire logic i_internal_reference,
  input wire logic i_external_reference,
  input wire logic i_int_base_clock,
  input wire logic i_int_freq_ok,
  // Clock outputs, generator enables and interrupt
  output logic o_osc_out_clock,
  output logic o_gen_out_clock,
  output logic o_ext_gen_on,
  output logic o_int_gen_on,
  output logic o_irq,
  // AXI4-Lite slave
  input wire logic [CLKSM_ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [CLKSM_ADDR_W-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready
);

  localparam int CW = $clog2(STAB_COUNT);

  // Stabilisation count must be a power of two for the tick divider
  if (STAB_COUNT < 2 || (STAB_COUNT & (STAB_COUNT - 1)) != 0)
  begin : g_check
    $error("STAB_COUNT must be a power of two of at least two");
  end

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [5:0] pin_raw; // Raw pins, one per synchroniser
  logic [5:0] pin_lvl; // Settled levels
  logic [5:0] pin_rise; // Rising edge pulses
  logic [5:0] pin_fall; // Falling edge pulses

  assign pin_raw = {i_int_freq_ok, i_int_base_clock, i_external_reference,
                    i_internal_reference, i_internal_clock,
                    i_external_clock};

  for (genvar g = 0; g < 6; g++) begin : g_sync
    clksm_sync #(
      .STAGES(CLKSM_SYNC_STAGES)
    ) u_sync (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_async(pin_raw[g]),
      .o_level(pin_lvl[g]),
      .o_rise(pin_rise[g]),
      .o_fall(pin_fall[g])
    );
  end

  // ************************************************************
  // Control and status state
  // ************************************************************
  logic sel_ext; // Clock source select, one picks external
  logic ext_req; // Software request for the external generator
  logic int_req; // Software request for the internal generator
  logic monitor_on; // Clock monitor enable
  logic monitor_irq_enable; // Monitor interrupt enable
  logic ext_stable; // External stable flag
  logic int_stable; // Internal stable flag
  logic [1:0] inactive; // [0] external, [1] internal inactive flag
  logic [1:0] seen; // Edge seen in the current low reference phase
  logic [1:0] miss [2]; // Consecutive missed low phases
  logic [CW-1:0] stab_cnt; // Stabilisation divider on external edges
  logic [CLKSM_IRQ_W-1:0] irq_status; // Sticky event bits
  logic [CLKSM_IRQ_W-1:0] irq_mask; // Interrupt mask
  logic ext_s1, ext_s2; // External side of the switch
  logic int_s1, int_s2; // Internal side of the switch
  logic osc_prev; // Oscillator output one cycle ago

  // Detector inputs: edge under test and reference phase per side
  logic [1:0] det_edge;
  logic [1:0] det_ref_low;
  logic [1:0] det_ref_rise;
  assign det_edge = {pin_fall[4], pin_fall[0]};
  assign det_ref_low = {~pin_lvl[3], ~pin_lvl[2]};
  assign det_ref_rise = {pin_rise[3], pin_rise[2]};

  // ************************************************************
  // Activity detectors (index 0 external, index 1 internal)
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      inactive <= 2'b00;
      seen <= 2'b00;
      miss[0] <= 2'h0;
      miss[1] <= 2'h0;
    end else begin
      for (int d = 0; d < 2; d++) begin
        if (det_edge[d] && det_ref_low[d]) begin
          // Edge while the reference is low clears the indicator
          seen[d] <= 1'b1;
          inactive[d] <= 1'b0;
          miss[d] <= 2'h0;
        end else if (det_ref_rise[d]) begin
          // End of a low phase: count it if it held no edge
          seen[d] <= 1'b0;
          if (seen[d]) begin
            miss[d] <= 2'h0;
          end else if (miss[d] == CLKSM_MISS_LIMIT - 2'h1) begin
            miss[d] <= CLKSM_MISS_LIMIT;
            inactive[d] <= 1'b1;
          end else if (miss[d] != CLKSM_MISS_LIMIT) begin
            miss[d] <= miss[d] + 2'h1;
          end
        end
      end
    end
  end

  // ************************************************************
  // External stabilisation divider and stable flag
  // ************************************************************
  // Divider restarts whenever the generator is off or the clock was
  // lost, so a recovered crystal waits the full count again.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stab_cnt <= '0;
      ext_stable <= 1'b0;
    end else if (!o_ext_gen_on || inactive[0]) begin
      stab_cnt <= '0;
      ext_stable <= 1'b0;
    end else if (pin_fall[0]) begin
      stab_cnt <= stab_cnt + CW'(1);
      // Tick falls when the divider wraps after the full count
      if (stab_cnt == CW'(STAB_COUNT - 1)) begin
        ext_stable <= 1'b1;
      end
    end
  end

  // Internal stable flag follows the frequency loop measurement
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      int_stable <= 1'b0;
    end else begin
      int_stable <= o_int_gen_on & pin_lvl[5] & ~inactive[1];
    end
  end

  // ************************************************************
  // Bus write channel
  // ************************************************************
  logic aw_held; // Write address captured
  logic w_held; // Write data captured
  logic [CLKSM_ADDR_W-1:0] aw_addr; // Captured write address
  logic [31:0] w_data; // Captured write data
  logic [3:0] w_strb; // Captured byte enables
  logic wr_fire; // Register write happens this cycle
  logic wr_ctrl; // Write hits the control register low byte
  logic wr_mask; // Write hits the mask register low byte
  logic wr_hit; // Write address is mapped

  assign o_s_axi_awready = ~aw_held & ~o_s_axi_bvalid;
  assign o_s_axi_wready = ~w_held & ~o_s_axi_bvalid;
  assign wr_fire = aw_held & w_held & ~o_s_axi_bvalid;
  assign wr_hit = (aw_addr == CLKSM_OFF_CTRL) ||
                  (aw_addr == CLKSM_OFF_STATUS) ||
                  (aw_addr == CLKSM_OFF_IRQ_STATUS) ||
                  (aw_addr == CLKSM_OFF_IRQ_MASK);
  assign wr_ctrl = wr_fire & w_strb[0] & (aw_addr == CLKSM_OFF_CTRL);
  assign wr_mask = wr_fire & w_strb[0] & (aw_addr == CLKSM_OFF_IRQ_MASK);

  // Address and data are taken in either order, then answered
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= CLKSM_RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= i_s_axi_wdata;
        w_strb <= i_s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= wr_hit ? CLKSM_RESP_OKAY : CLKSM_RESP_SLVERR;
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Control register with its gated bits
  // ************************************************************
  logic force_int; // Monitor forces the internal clock
  logic force_ext; // Monitor forces the external clock
  logic want_ext; // Requested new select value
  logic all_ready; // Both generators on and both stable
  assign force_int = monitor_on & inactive[0] & sel_ext;
  assign force_ext = monitor_on & inactive[1] & ~sel_ext;
  assign want_ext = w_data[CLKSM_CTRL_SEL_EXT];
  assign all_ready = o_ext_gen_on & o_int_gen_on & ext_stable & int_stable;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_ext <= CLKSM_CTRL_RESET[CLKSM_CTRL_SEL_EXT];
      ext_req <= CLKSM_CTRL_RESET[CLKSM_CTRL_EXT_GEN_ON];
      int_req <= CLKSM_CTRL_RESET[CLKSM_CTRL_INT_GEN_ON];
      monitor_on <= CLKSM_CTRL_RESET[CLKSM_CTRL_MONITOR_ON];
      monitor_irq_enable <= CLKSM_CTRL_RESET[CLKSM_CTRL_MONITOR_IRQ_ENABLE];
    end else begin
      // A forced switch overrides any software select in that cycle
      if (force_int) begin
        sel_ext <= 1'b0;
      end else if (force_ext) begin
        sel_ext <= 1'b1;
      end else if (wr_ctrl && want_ext != sel_ext &&
                   o_ext_gen_on && o_int_gen_on &&
                   (want_ext ? ext_stable : int_stable)) begin
        sel_ext <= want_ext;
      end
      if (wr_ctrl) begin
        ext_req <= w_data[CLKSM_CTRL_EXT_GEN_ON];
        int_req <= w_data[CLKSM_CTRL_INT_GEN_ON];
        // Clearing is always allowed; setting needs everything ready
        if (!w_data[CLKSM_CTRL_MONITOR_ON] || all_ready) begin
          monitor_on <= w_data[CLKSM_CTRL_MONITOR_ON];
        end
        // Uses the old monitor bit, so a joint write while the monitor is off leaves it clear
        if (!w_data[CLKSM_CTRL_MONITOR_IRQ_ENABLE] || monitor_on) begin
          monitor_irq_enable <= w_data[CLKSM_CTRL_MONITOR_IRQ_ENABLE];
        end
      end
    end
  end

  // Generator enables: the selected one stays on until deselected
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ext_gen_on <= CLKSM_CTRL_RESET[CLKSM_CTRL_EXT_GEN_ON];
      o_int_gen_on <= CLKSM_CTRL_RESET[CLKSM_CTRL_INT_GEN_ON];
    end else begin
      o_ext_gen_on <= ext_req | sel_ext;
      o_int_gen_on <= int_req | ~sel_ext;
    end
  end

  // ************************************************************
  // Glitch-free switch
  // ************************************************************
  // Each side's two stages advance only on a falling edge of its own
  // clock, so the enable changes while that clock is low.
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      int_s1 <= 1'b1;
      int_s2 <= 1'b1;
    end else begin
      // A dead clock cannot step its side, so it is cleared directly
      if (monitor_on && inactive[0]) begin
        ext_s1 <= 1'b0;
        ext_s2 <= 1'b0;
      end else if (pin_fall[0]) begin
        ext_s1 <= sel_ext & ~int_s2;
        ext_s2 <= ext_s1;
      end
      if (monitor_on && inactive[1]) begin
        int_s1 <= 1'b0;
        int_s2 <= 1'b0;
      end else if (pin_fall[1]) begin
        int_s1 <= ~sel_ext & ~ext_s2;
        int_s2 <= int_s1;
      end
    end
  end

  // ************************************************************
  // Clock outputs
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_osc_out_clock <= 1'b0;
      osc_prev <= 1'b0;
      o_gen_out_clock <= 1'b0;
    end else begin
      // Output is low while neither side holds the switch
      o_osc_out_clock <= (pin_lvl[0] & ext_s2) |
                         (pin_lvl[1] & int_s2);
      osc_prev <= o_osc_out_clock;
      if (o_osc_out_clock && !osc_prev) begin
        o_gen_out_clock <= ~o_gen_out_clock;
      end
    end
  end

  // ************************************************************
  // Bus read channel
  // ************************************************************
  logic rd_status_clr; // Read of the interrupt status this cycle
  logic [31:0] rd_word; // Word selected by the read address
  logic rd_hit; // Read address is mapped

  assign o_s_axi_arready = ~o_s_axi_rvalid;
  assign rd_status_clr = i_s_axi_arvalid & o_s_axi_arready &
                         (i_s_axi_araddr == CLKSM_OFF_IRQ_STATUS);

  // Read mux over the four words
  always_comb begin
    rd_word = 32'h0;
    rd_hit = 1'b1;
    case (i_s_axi_araddr)
      CLKSM_OFF_CTRL: begin
        rd_word[CLKSM_CTRL_SEL_EXT] = sel_ext;
        rd_word[CLKSM_CTRL_EXT_GEN_ON] = o_ext_gen_on;
        rd_word[CLKSM_CTRL_INT_GEN_ON] = o_int_gen_on;
        rd_word[CLKSM_CTRL_MONITOR_ON] = monitor_on;
        rd_word[CLKSM_CTRL_MONITOR_IRQ_ENABLE] = monitor_irq_enable;
      end
      CLKSM_OFF_STATUS: begin
        rd_word[CLKSM_ST_EXT_STABLE] = ext_stable;
        rd_word[CLKSM_ST_INT_STABLE] = int_stable;
        rd_word[CLKSM_ST_EXT_INACTIVE] = inactive[0];
        rd_word[CLKSM_ST_INT_INACTIVE] = inactive[1];
        rd_word[CLKSM_ST_EXT_SIDE] = ext_s2;
        rd_word[CLKSM_ST_INT_SIDE] = int_s2;
      end
      CLKSM_OFF_IRQ_STATUS: begin
        rd_word[CLKSM_IRQ_W-1:0] = irq_status;
      end
      CLKSM_OFF_IRQ_MASK: begin
        rd_word[CLKSM_IRQ_W-1:0] = irq_mask;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Answer one cycle after the address is taken
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0;
      o_s_axi_rresp <= CLKSM_RESP_OKAY;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rdata <= rd_word;
      o_s_axi_rresp <= rd_hit ? CLKSM_RESP_OKAY : CLKSM_RESP_SLVERR;
    end else if (o_s_axi_rvalid && i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  logic [1:0] inactive_prev; // For rising detection of inactivity
  logic ext_stable_prev; // For rising detection of stability
  logic [CLKSM_IRQ_W-1:0] irq_event; // Events of this cycle
  logic [CLKSM_IRQ_W-1:0] irq_gate; // Mask, with monitor enable on bit 0

  always_comb begin
    irq_event = '0;
    irq_event[CLKSM_IRQ_MONITOR_FLAG] = force_int | force_ext;
    irq_event[CLKSM_IRQ_EXT_STABLE] = ext_stable & ~ext_stable_prev;
    irq_event[CLKSM_IRQ_EXT_INACTIVE] = inactive[0] & ~inactive_prev[0];
    irq_event[CLKSM_IRQ_INT_INACTIVE] = inactive[1] & ~inactive_prev[1];
    irq_gate = irq_mask;
    irq_gate[CLKSM_IRQ_MONITOR_FLAG] = irq_mask[CLKSM_IRQ_MONITOR_FLAG] &
                                       monitor_irq_enable;
  end

  // Sticky bits; a new event beats the clear of a read
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_status <= '0;
      irq_mask <= CLKSM_IRQ_MASK_RESET;
      inactive_prev <= 2'b00;
      ext_stable_prev <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      inactive_prev <= inactive;
      ext_stable_prev <= ext_stable;
      irq_status <= (rd_status_clr ? '0 : irq_status) | irq_event;
      if (wr_mask) begin
        irq_mask <= w_data[CLKSM_IRQ_W-1:0];
      end
      o_irq <= |(irq_status & irq_gate);
    end
  end

endmodule
`default_nettype wire

// ### hw/clksm_pkg.sv
// Constants for the clock select and monitor block: register map,
// field positions, reset values and detector figures.
// Assumes a 32-bit AXI4-Lite register bus and a single system clock.

package clksm_pkg;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam int CLKSM_ADDR_W = 4;
  localparam logic [3:0] CLKSM_OFF_CTRL = 4'h0;
  localparam logic [3:0] CLKSM_OFF_STATUS = 4'h4;
  localparam logic [3:0] CLKSM_OFF_IRQ_STATUS = 4'h8;
  localparam logic [3:0] CLKSM_OFF_IRQ_MASK = 4'hc;

  // ************************************************************
  // Control register fields
  // ************************************************************
  localparam int CLKSM_CTRL_SEL_EXT = 0;
  localparam int CLKSM_CTRL_EXT_GEN_ON = 1;
  localparam int CLKSM_CTRL_INT_GEN_ON = 2;
  localparam int CLKSM_CTRL_MONITOR_ON = 3;
  localparam int CLKSM_CTRL_MONITOR_IRQ_ENABLE = 4;
  localparam logic [4:0] CLKSM_CTRL_RESET = 5'h04;

  // ************************************************************
  // Status register fields
  // ************************************************************
  localparam int CLKSM_ST_EXT_STABLE = 0;
  localparam int CLKSM_ST_INT_STABLE = 1;
  localparam int CLKSM_ST_EXT_INACTIVE = 2;
  localparam int CLKSM_ST_INT_INACTIVE = 3;
  localparam int CLKSM_ST_EXT_SIDE = 4;
  localparam int CLKSM_ST_INT_SIDE = 5;

  // ************************************************************
  // Interrupt status and mask fields
  // ************************************************************
  localparam int CLKSM_IRQ_W = 4;
  localparam int CLKSM_IRQ_MONITOR_FLAG = 0;
  localparam int CLKSM_IRQ_EXT_STABLE = 1;
  localparam int CLKSM_IRQ_EXT_INACTIVE = 2;
  localparam int CLKSM_IRQ_INT_INACTIVE = 3;
  localparam logic [3:0] CLKSM_IRQ_MASK_RESET = 4'h0;

  // ************************************************************
  // Detector figures and bus answers
  // ************************************************************
  localparam int CLKSM_STAB_CYCLES = 4096;
  localparam logic [1:0] CLKSM_MISS_LIMIT = 2'h2;
  localparam int CLKSM_SYNC_STAGES = 3;
  localparam logic [1:0] CLKSM_RESP_OKAY = 2'h0;
  localparam logic [1:0] CLKSM_RESP_SLVERR = 2'h2;

endpackage

// ### hw/clksm_sync.sv
// Pin synchroniser with a debounced level and edge pulses.
// Assumes i_async is unrelated to i_clk; outputs lag it a few cycles.
`timescale 1ns/1ps
`default_nettype none

module clksm_sync #(
  parameter int STAGES = 3
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_async,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);

  // Sampling chain; only stage 0 sees the raw pin
  logic [STAGES-1:0] chain;

  // Refuse chains too short to hold a two-stage agreement
  if (STAGES < 3) begin : g_check
    $error("clksm_sync needs at least three stages");
  end

  // ************************************************************
  // Sampling chain
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      chain <= '0;
    end else begin
      chain <= {chain[STAGES-2:0], i_async};
    end
  end

  // ************************************************************
  // Level update once the last two stages agree
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_level <= 1'b0;
      o_rise <= 1'b0;
      o_fall <= 1'b0;
    end else if (chain[STAGES-1] == chain[STAGES-2] &&
                 chain[STAGES-1] != o_level) begin
      // Agreement on a new value: one edge pulse
      o_level <= chain[STAGES-1];
      o_rise <= chain[STAGES-1];
      o_fall <= ~chain[STAGES-1];
    end else begin
      o_rise <= 1'b0;
      o_fall <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### dv/clksm_clocks.sv
// Far-side model: crystal, internal oscillator, monitor references.
// Assumes the bench raises i_stop_ext to emulate a dead crystal.
`timescale 1ns/1ps
`default_nettype none
module clksm_clocks (
  input wire logic i_stop_ext,
  output logic o_ext,
  output logic o_int,
  output logic o_ref,
  output logic o_base
);
  // Clock edges never meet rising i_clk edges, so sampled periods are exact
  initial o_ext = 1'b0;
  initial o_int = 1'b0;
  initial o_ref = 1'b0;
  initial o_base = 1'b0;
  // Dead crystal sits low instead of holding its last level
  always #200 o_ext = i_stop_ext ? 1'b0 : !o_ext;
  always #300 o_int = !o_int;
  always #200 o_base = !o_base;
  // Four times slower than the clocks it watches
  always #800 o_ref = !o_ref;
endmodule
`default_nettype wire

// ### dv/clksm_props.sv
// Port checker for the clock select and monitor block.
// Assumes one i_clk domain; bound onto every clksm_top.
`timescale 1ns/1ps
`default_nettype none
module clksm_props (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic o_osc_out_clock,
  input wire logic o_gen_out_clock,
  input wire logic o_ext_gen_on,
  input wire logic o_int_gen_on,
  input wire logic o_irq,
  input wire logic o_s_axi_arready,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic [31:0] o_s_axi_rdata
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  gen_halves_a: assert property ($rose(o_osc_out_clock) |->
    ##[0:1] $changed(o_gen_out_clock)) else $error("gen missed");
  gen_cause_a: assert property ($changed(o_gen_out_clock) |->
    o_osc_out_clock) else $error("gen moved alone");
  high_pulse_a: assert property ($rose(o_osc_out_clock) |=>
    o_osc_out_clock) else $error("high glitch");
  low_pulse_a: assert property ($fell(o_osc_out_clock) |=>
    !o_osc_out_clock) else $error("low glitch");
  gen_kept_a: assert property (o_ext_gen_on || o_int_gen_on)
    else $error("both generators off");
  ar_block_a: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read taken while busy");
  read_answer_a: assert property (i_s_axi_arvalid && o_s_axi_arready
    |=> o_s_axi_rvalid) else $error("read answer late");
  rdata_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready
    |=> o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("rd lost");
  irq_c: cover property (o_irq);
  ext_only_c: cover property (o_ext_gen_on && !o_int_gen_on);
  rd_wait_c: cover property (o_s_axi_rvalid && !i_s_axi_rready);
endmodule
bind clksm_top clksm_props chk (.*);
`default_nettype wire

// ### dv/clksm_top_test.sv
// Bench for clksm_top: AXI4-Lite master, model and clock partner.
// Assumes STAB_COUNT 16 and the partner clock periods.
`timescale 1ns/1ps
`default_nettype none
module clksm_top_test;
  import clksm_pkg::*;
  logic i_clk, i_reset_n, i_external_clock, i_internal_clock, stop;
  logic i_internal_reference, i_int_base_clock, i_int_freq_ok, o_irq;
  logic o_osc_out_clock, o_gen_out_clock, o_ext_gen_on, o_int_gen_on;
  logic i_s_axi_awvalid, o_s_axi_awready, i_s_axi_wvalid, o_s_axi_wready;
  logic o_s_axi_bvalid, i_s_axi_bready, i_s_axi_arvalid, o_s_axi_arready;
  logic o_s_axi_rvalid, i_s_axi_rready;
  logic [CLKSM_ADDR_W-1:0] i_s_axi_awaddr, i_s_axi_araddr;
  logic [31:0] i_s_axi_wdata, o_s_axi_rdata, d, rnd;
  logic [3:0] i_s_axi_wstrb;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp, r;
  int failures, comparisons, m_ctrl, p;
  wire logic i_external_reference = i_internal_reference;
  clksm_top #(.STAB_COUNT(16)) uut (.*);
  clksm_clocks src (.i_stop_ext(stop), .o_ext(i_external_clock),
    .o_int(i_internal_clock), .o_ref(i_internal_reference),
    .o_base(i_int_base_clock));
  always #12.5 i_clk = !i_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Write: address and data offered together, bready left high
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= v;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    do @(posedge i_clk); while (!(o_s_axi_awready && o_s_axi_wready));
    i_s_axi_awvalid <= 1'b0;
    i_s_axi_wvalid <= 1'b0;
    do @(posedge i_clk); while (!o_s_axi_bvalid);
    // Response code is taken at the handshake edge
    r = o_s_axi_bresp;
  endtask
  // Read: rready raised late so the answer must stand
  task automatic rd(input logic [3:0] a);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    do @(posedge i_clk); while (!o_s_axi_arready);
    i_s_axi_arvalid <= 1'b0;
    do @(posedge i_clk); while (!o_s_axi_rvalid);
    i_s_axi_rready <= 1'b1;
    @(posedge i_clk);
    d = o_s_axi_rdata;
    r = o_s_axi_rresp;
    i_s_axi_rready <= 1'b0;
  endtask
  // Time between two output clock rises, in i_clk cycles
  task automatic per(output int n);
    realtime t;
    @(posedge o_osc_out_clock);
    t = $realtime;
    @(posedge o_osc_out_clock);
    n = int'(($realtime - t) / 25.0);
  endtask
  task automatic test_done;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    test_done;
  end
  initial begin
    {i_clk, i_reset_n, stop, i_s_axi_awvalid, i_s_axi_wvalid} = '0;
    {i_s_axi_arvalid, i_s_axi_rready, i_s_axi_awaddr} = '0;
    {i_s_axi_araddr, i_s_axi_wdata} = '0;
    {i_s_axi_bready, i_int_freq_ok, i_s_axi_wstrb} = 6'h3f;
    rnd = 32'h2d40;
    m_ctrl = 32'h04;
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rd(CLKSM_OFF_CTRL);
    chk(d, m_ctrl);
    chk(32'({o_ext_gen_on, o_int_gen_on}), 32'h1);
    rd(4'h2);
    chk(32'(r), 32'(CLKSM_RESP_SLVERR));
    wr(4'h6, 32'h0);
    chk(32'(r), 32'(CLKSM_RESP_SLVERR));
    wr(CLKSM_OFF_CTRL, 32'h19);
    chk(32'(r), 32'(CLKSM_RESP_OKAY));
    rd(CLKSM_OFF_CTRL);
    chk(d, m_ctrl);
    rnd = lfsr(rnd);
    wr(CLKSM_OFF_IRQ_MASK, rnd);
    rd(CLKSM_OFF_IRQ_MASK);
    chk(d, 32'(rnd[3:0]));
    $display("reset and refusal test done");
    wr(CLKSM_OFF_IRQ_MASK, 32'h3);
    m_ctrl = 32'h06;
    wr(CLKSM_OFF_CTRL, m_ctrl);
    repeat (150) @(posedge i_clk);
    rd(CLKSM_OFF_STATUS);
    chk(32'(d[0]), 32'h0);
    repeat (240) @(posedge i_clk);
    rd(CLKSM_OFF_STATUS);
    chk(32'(d[0]), 32'h1);
    chk(32'(o_irq), 32'h1);
    rd(CLKSM_OFF_IRQ_STATUS);
    chk(d, 32'h2);
    chk(32'(o_irq), 32'h0);
    m_ctrl = 32'h03;
    wr(CLKSM_OFF_CTRL, m_ctrl);
    repeat (300) @(posedge i_clk);
    rd(CLKSM_OFF_CTRL);
    chk(d, m_ctrl);
    per(p);
    chk(p, 16);
    $display("switch test done");
    for (int i = 0; i < 3; i++) begin
      m_ctrl = i == 0 ? 32'h07 : i == 1 ? 32'h0f : 32'h1f;
      wr(CLKSM_OFF_CTRL, m_ctrl);
    end
    rd(CLKSM_OFF_CTRL);
    chk(d, m_ctrl);
    wr(CLKSM_OFF_IRQ_MASK, 32'h1);
    stop <= 1'b1;
    repeat (500) @(posedge i_clk);
    chk(32'(o_irq), 32'h1);
    rd(CLKSM_OFF_STATUS);
    chk(d, 32'h26);
    per(p);
    chk(p, 24);
    stop <= 1'b0;
    repeat (200) @(posedge i_clk);
    rd(CLKSM_OFF_STATUS);
    chk(32'(d[2]), 32'h0);
    $display("monitor test done");
    test_done;
  end
endmodule
`default_nettype wire
